// ---- bay_io_asserts.sv ----
// Bus timing, reset defaults and write-only changes of the I/O matrix outputs
`include "bay_io_defines.vh"
module bay_io_asserts #(parameter N_DO = 8, parameter N_LED = 16) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [`ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire avs_waitrequest_o,
  input wire [N_DO-1:0] relay_o,
  input wire [N_LED-1:0] led_yellow_o,
  input wire [31:0] logic_in_o,
  input wire [2:0] active_group_o,
  input wire event_valid_o,
  input wire [15:0] event_code_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire req = avs_read_i || avs_write_i;
  wire lin_wr = avs_write_i && (avs_address_i == `A_LIN_SET || avs_address_i == `A_LIN_CLR);
  wire grp_wr = avs_write_i && (avs_address_i == `A_GRP_REQ || avs_address_i == `A_GRP_USED);
  wire col_wr = avs_write_i && avs_address_i == `A_LED_COLOR;
  reg mask_seen_reg;
  reg [31:0] mode_reg;
  // Sticky flag: a later zero mask is not tracked, so the check only gets looser
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mask_seen_reg <= 1'b0;
      mode_reg <= 32'h0000_0000;
    end
    else if (avs_write_i)
    begin
      if (avs_address_i == `A_EV_MASK && avs_writedata_i != 32'h0000_0000)
        mask_seen_reg <= 1'b1;
      if (avs_address_i == `A_LIN_MODE)
        mode_reg <= avs_writedata_i;
    end
  end
  sequence s_first_wait;
    avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o;
  endsequence
  AST_REQ_WAITS: assert property ($rose(req) |-> s_first_wait ##1 s_answer)
    else $error("request not answered after one wait cycle");
  AST_RESET_DEFAULTS: assert property (!$past(nrst_i) |-> relay_o == 0 && led_yellow_o == 0 && active_group_o == 0)
    else $error("outputs not at defaults after reset");
  AST_LIN_HOLD: assert property ($changed(logic_in_o) |-> $past(lin_wr, 1) || $past(lin_wr, 2) || $past(lin_wr, 3))
    else $error("logical input changed without a write");
  AST_LIN_PULSE: assert property ((logic_in_o & mode_reg) != 0 |=> (logic_in_o & $past(logic_in_o) & mode_reg) == 0)
    else $error("pulse mode bit high for two cycles");
  AST_GROUP_HOLD: assert property ($changed(active_group_o) |-> $past(grp_wr, 1) || $past(grp_wr, 2) || $past(grp_wr, 3))
    else $error("active group changed without a request");
  AST_COLOUR_HOLD: assert property ($changed(led_yellow_o) |-> $past(col_wr, 1) || $past(col_wr, 2))
    else $error("led colour changed without a write");
  AST_EV_MASKED: assert property (event_valid_o |-> mask_seen_reg)
    else $error("event raised with all masks clear");
  AST_EV_CODE: assert property ($changed(event_code_o) |-> event_valid_o)
    else $error("event code changed without an event");
endmodule
bind bay_io_matrix bay_io_asserts #(.N_DO(N_DO), .N_LED(N_LED)) chk (.core_clk_i, .nrst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .relay_o, .led_yellow_o, .logic_in_o,
  .active_group_o, .event_valid_o, .event_code_o);

// ---- bay_io_defines.vh ----
// Register map, field positions and timing constants of the bay I/O matrix
`ifndef BAY_IO_DEFINES_VH
`define BAY_IO_DEFINES_VH
`define CLK_HZ 10000000
`define TICK_MS_HZ 1000
`define TICK_DIV (`CLK_HZ / `TICK_MS_HZ)
`define DELAY_MAX_MS 1800000
`define DELAY_W 21
`define ADDR_W 8
`define A_DI_POL 8'h00
`define A_DI_STAT 8'h04
`define A_DO_POL 8'h08
`define A_DO_STAT 8'h0C
`define A_LED_COLOR 8'h10
`define A_LED_STAT 8'h14
`define A_LIN_SET 8'h18
`define A_LIN_CLR 8'h1C
`define A_LIN_MODE 8'h20
`define A_LIN_STAT 8'h24
`define A_LOUT_STAT 8'h28
`define A_NET_LO 8'h2C
`define A_NET_HI 8'h30
`define A_QUAL_LO 8'h34
`define A_QUAL_HI 8'h38
`define A_EV_MASK 8'h3C
`define A_EV_CODE 8'h40
`define A_CMD 8'h44
`define A_STG_SEL 8'h48
`define A_STG_STAT 8'h4C
`define A_STG_CNT 8'h50
`define A_BLK_SRC 8'h54
`define A_GRP_REQ 8'h58
`define A_GRP_USED 8'h5C
`define A_ROUTE_SRC 8'h60
`define A_ROUTE_LAT 8'h64
`define A_DLY_SEL 8'h68
`define A_DLY_ON 8'h6C
`define A_DLY_OFF 8'h70
`define A_REC_RD 8'h74
`define A_REC_DATA 8'h78
`define CMD_CLR_STAT 0
`define CMD_CLR_REC 1
`define CMD_CLR_LATCH 2
`define COND_NORMAL 2'h0
`define COND_START 2'h1
`define COND_TRIP 2'h2
`define COND_BLOCKED 2'h3
`define GRP_DEFAULT 8'h01
`define REC_DEPTH 12
`define EV_LIN 2'h0
`define EV_LOUT 2'h1
`define EV_STAGE 2'h2
`endif

// ---- bay_io_matrix.v ----
// Binary I/O conditioning, output matrix, logical signals and stage bookkeeping
`include "bay_io_defines.vh"
// Operation
// - Per-input polarity inverts rest-closed input sense
// - Separate activation and release delays per input
// - Output polarity selectable, rest-open after reset
// - Rest-closed outputs cleared only by full reset
// - Non-latched route drops with its source
// - Latched route holds until source low and clear
// - 32 logical in/out, 64 networked status/quality
// - Logical inputs hold mode by default
// - Pulse mode input returns to 0 itself
// - Quality bit 1 means bad message
// - Event masks cleared at reset gate history
// - Only logical in/out changes raise events, not gate activity
// - Logical in/out give ON and OFF events
// - Stage condition normal, start, trip or blocked
// - Stage start, trip, block counters clearable
// - Twelve-entry operation record, clearable
// - General event record cannot be cleared
// - Stage block source is selectable
// - Blocked indication routable to relay or LED
// - Eight parameter groups, one enabled at reset
// - LED colour green or yellow, green at reset
// - Group one wins over group eight
module bay_io_matrix #(
  parameter N_DI = 8,
  parameter N_DO = 8,
  parameter N_LED = 16,
  parameter N_STG = 4,
  parameter TICK_DIV = `TICK_DIV
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [`ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire [N_DI-1:0] di_raw_i,
  input wire [31:0] logic_out_i,
  input wire [63:0] net_status_i,
  input wire [63:0] net_msg_valid_i,
  input wire [N_STG-1:0] stage_start_i,
  input wire [N_STG-1:0] stage_trip_i,
  input wire [31:0] stage_fault_value_i,
  input wire [31:0] stage_prefault_value_i,
  input wire [31:0] timestamp_i,
  input wire back_key_i,
  input wire mimic_shown_i,
  output reg [N_DO-1:0] relay_o,
  output reg [N_LED-1:0] led_on_o,
  output reg [N_LED-1:0] led_yellow_o,
  output reg [31:0] logic_in_o,
  output reg [N_DI-1:0] di_state_o,
  output reg [2:0] active_group_o,
  output reg event_valid_o,
  output reg [15:0] event_code_o
);
  localparam N_SRC = 32;
  localparam N_DST = N_DO + N_LED;
  localparam S_IDLE = 2'b01;
  localparam S_ACK = 2'b10;

  reg [1:0] bus_state_reg;
  reg [N_DI-1:0] di_pol_reg;
  reg [N_DO-1:0] do_pol_reg;
  reg [N_LED-1:0] led_color_reg;
  reg [31:0] lin_mode_reg;
  reg [31:0] lin_reg;
  reg [31:0] lout_reg;
  reg [127:0] ev_mask_reg;
  reg [15:0] ev_last_reg;
  reg [7:0] grp_used_reg;
  reg [7:0] grp_req_reg;
  reg [4:0] route_src_reg [0:N_DST-1];
  reg [N_DST-1:0] route_lat_reg;
  reg [N_DST-1:0] latch_reg;
  reg [4:0] blk_src_reg [0:N_STG-1];
  reg [7:0] stg_sel_reg;
  reg [7:0] dly_sel_reg;
  reg [`DELAY_W-1:0] dly_on_reg [0:N_DI-1];
  reg [`DELAY_W-1:0] dly_off_reg [0:N_DI-1];
  reg [`DELAY_W-1:0] dly_cnt_reg [0:N_DI-1];
  reg [15:0] tick_cnt_reg;
  reg tick_reg;
  reg [15:0] cnt_start_reg [0:N_STG-1];
  reg [15:0] cnt_trip_reg [0:N_STG-1];
  reg [15:0] cnt_blk_reg [0:N_STG-1];
  reg [N_STG-1:0] start_d_reg;
  reg [N_STG-1:0] trip_d_reg;
  reg [N_STG-1:0] blk_d_reg;
  reg [103:0] rec_mem [0:`REC_DEPTH-1];
  reg [3:0] rec_wr_reg;
  reg [3:0] rec_cnt_reg;
  reg [3:0] rec_rd_reg;
  reg [1:0] rec_word_reg;
  reg [15:0] gen_count_reg;
  reg clr_pulse_reg;

  wire wr_acc = avs_write_i && bus_state_reg[1];
  wire [N_DI-1:0] di_sense = di_raw_i ^ di_pol_reg;
  wire [63:0] net_quality = ~net_msg_valid_i;
  wire [N_STG-1:0] stage_blocked;
  wire [N_SRC-1:0] src_vec;
  reg [N_DST-1:0] dst_level;
  reg [31:0] rd_mux;
  reg [2:0] grp_pick;
  integer k, j, m;

  // Single wait cycle keeps read data registered
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !bus_state_reg[1];

  function [31:0] sel_bit;
    input [N_SRC-1:0] vec;
    input [4:0] idx;
    begin
      sel_bit = {31'd0, vec[idx]};
    end
  endfunction

  // Source vector: stage flags, digital inputs, logical signals
  assign src_vec = {lout_reg[7:0], lin_reg[7:0],
    {(16-N_DI-N_STG){1'b0}}, stage_blocked, di_state_o} | {N_SRC{1'b0}};

  // Block sources exclude other stages' blocked flags to avoid a loop
  wire [N_SRC-1:0] src_nb = {lout_reg[7:0], lin_reg[7:0], {(16-N_DI-N_STG){1'b0}},
    stage_trip_i | stage_start_i, di_state_o};

  genvar g;
  generate
    for (g = 0; g < N_STG; g = g + 1)
    begin : stg_blk
      assign stage_blocked[g] = sel_bit(src_nb, blk_src_reg[g]) != 32'h0000_0000;
    end
  endgenerate

  // Input delay filters
  generate
    for (g = 0; g < N_DI; g = g + 1)
    begin : di_filt
      always @(posedge core_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          dly_cnt_reg[g] <= {`DELAY_W{1'b0}};
          di_state_o[g] <= 1'b0;
        end
        else if (di_sense[g] == di_state_o[g])
          dly_cnt_reg[g] <= {`DELAY_W{1'b0}};
        else if (dly_cnt_reg[g] >= (di_sense[g] ? dly_on_reg[g] : dly_off_reg[g]))
        begin
          di_state_o[g] <= di_sense[g];
          dly_cnt_reg[g] <= {`DELAY_W{1'b0}};
        end
        else if (tick_reg)
          dly_cnt_reg[g] <= dly_cnt_reg[g] + 1'b1;
      end
    end
  endgenerate

  // Output matrix levels
  always @*
  begin
    for (j = 0; j < N_DST; j = j + 1)
      dst_level[j] = src_vec[route_src_reg[j]];
  end

  // Parameter group priority encoder, lowest index wins
  always @*
  begin
    grp_pick = active_group_o;
    for (m = 7; m >= 0; m = m - 1)
      if (grp_req_reg[m] && grp_used_reg[m])
        grp_pick = m[2:0];
  end

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `A_DI_POL: rd_mux = {{(32-N_DI){1'b0}}, di_pol_reg};
      `A_DI_STAT: rd_mux = {{(32-N_DI){1'b0}}, di_state_o};
      `A_DO_POL: rd_mux = {{(32-N_DO){1'b0}}, do_pol_reg};
      `A_DO_STAT: rd_mux = {{(32-N_DO){1'b0}}, relay_o};
      `A_LED_COLOR: rd_mux = {{(32-N_LED){1'b0}}, led_color_reg};
      `A_LED_STAT: rd_mux = {{(32-N_LED){1'b0}}, led_on_o};
      `A_LIN_MODE: rd_mux = lin_mode_reg;
      `A_LIN_STAT: rd_mux = lin_reg;
      `A_LOUT_STAT: rd_mux = lout_reg;
      `A_NET_LO: rd_mux = net_status_i[31:0];
      `A_NET_HI: rd_mux = net_status_i[63:32];
      `A_QUAL_LO: rd_mux = net_quality[31:0];
      `A_QUAL_HI: rd_mux = net_quality[63:32];
      `A_EV_MASK: rd_mux = ev_mask_reg[31:0];
      `A_EV_CODE: rd_mux = {gen_count_reg, ev_last_reg};
      `A_STG_SEL: rd_mux = {24'd0, stg_sel_reg};
      `A_STG_STAT: rd_mux = {27'd0, active_group_o,
        stage_blocked[stg_sel_reg[1:0]] ? `COND_BLOCKED :
        stage_trip_i[stg_sel_reg[1:0]] ? `COND_TRIP :
        stage_start_i[stg_sel_reg[1:0]] ? `COND_START : `COND_NORMAL};
      `A_STG_CNT: rd_mux = {cnt_trip_reg[stg_sel_reg[1:0]], cnt_start_reg[stg_sel_reg[1:0]]};
      `A_BLK_SRC: rd_mux = {cnt_blk_reg[stg_sel_reg[1:0]], 11'd0, blk_src_reg[stg_sel_reg[1:0]]};
      `A_GRP_REQ: rd_mux = {24'd0, grp_req_reg};
      `A_GRP_USED: rd_mux = {24'd0, grp_used_reg};
      `A_ROUTE_LAT: rd_mux = {{(32-N_DST){1'b0}}, route_lat_reg};
      `A_REC_RD: rd_mux = {24'd0, rec_cnt_reg, rec_rd_reg};
      `A_REC_DATA: rd_mux = (rec_word_reg == 2'd0) ? rec_mem[rec_rd_reg][31:0] :
        (rec_word_reg == 2'd1) ? rec_mem[rec_rd_reg][63:32] :
        (rec_word_reg == 2'd2) ? rec_mem[rec_rd_reg][95:64] : {24'd0, rec_mem[rec_rd_reg][103:96]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus, configuration and bookkeeping
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bus_state_reg <= S_IDLE;
      avs_readdata_o <= 32'h0000_0000;
      di_pol_reg <= {N_DI{1'b0}};
      do_pol_reg <= {N_DO{1'b0}};
      led_color_reg <= {N_LED{1'b0}};
      lin_mode_reg <= 32'h0000_0000;
      lin_reg <= 32'h0000_0000;
      lout_reg <= 32'h0000_0000;
      ev_mask_reg <= 128'd0;
      ev_last_reg <= 16'h0000;
      event_valid_o <= 1'b0;
      event_code_o <= 16'h0000;
      gen_count_reg <= 16'h0000;
      grp_used_reg <= `GRP_DEFAULT;
      grp_req_reg <= 8'h00;
      active_group_o <= 3'd0;
      route_lat_reg <= {N_DST{1'b0}};
      latch_reg <= {N_DST{1'b0}};
      relay_o <= {N_DO{1'b0}};
      led_on_o <= {N_LED{1'b0}};
      led_yellow_o <= {N_LED{1'b0}};
      logic_in_o <= 32'h0000_0000;
      stg_sel_reg <= 8'h00;
      dly_sel_reg <= 8'h00;
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
      start_d_reg <= {N_STG{1'b0}};
      trip_d_reg <= {N_STG{1'b0}};
      blk_d_reg <= {N_STG{1'b0}};
      rec_wr_reg <= 4'd0;
      rec_cnt_reg <= 4'd0;
      rec_rd_reg <= 4'd0;
      rec_word_reg <= 2'd0;
      clr_pulse_reg <= 1'b0;
      for (k = 0; k < N_DST; k = k + 1)
        route_src_reg[k] <= 5'd0;
      for (k = 0; k < N_STG; k = k + 1)
      begin
        blk_src_reg[k] <= 5'd31;
        cnt_start_reg[k] <= 16'h0000;
        cnt_trip_reg[k] <= 16'h0000;
        cnt_blk_reg[k] <= 16'h0000;
      end
      for (k = 0; k < N_DI; k = k + 1)
      begin
        dly_on_reg[k] <= {`DELAY_W{1'b0}};
        dly_off_reg[k] <= {`DELAY_W{1'b0}};
      end
    end
    else
    begin
      // Bus handshake
      event_valid_o <= 1'b0;
      if (bus_state_reg[0] && (avs_read_i || avs_write_i))
      begin
        bus_state_reg <= S_ACK;
        avs_readdata_o <= rd_mux;
      end
      else
        bus_state_reg <= S_IDLE;
      // Millisecond tick from the core clock
      tick_reg <= 1'b0;
      if (tick_cnt_reg == TICK_DIV - 1)
      begin
        tick_cnt_reg <= 16'h0000;
        tick_reg <= 1'b1;
      end
      else
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
      // Latch clear from the panel back key
      clr_pulse_reg <= back_key_i && mimic_shown_i;
      // Logical inputs: pulse mode bits fall back after one cycle
      lin_reg <= lin_reg & ~lin_mode_reg;
      lout_reg <= logic_out_i;
      if (wr_acc && avs_address_i == `A_LIN_SET)
        lin_reg <= (lin_reg & ~lin_mode_reg) | avs_writedata_i;
      if (wr_acc && avs_address_i == `A_LIN_CLR)
        lin_reg <= lin_reg & ~lin_mode_reg & ~avs_writedata_i;
      logic_in_o <= lin_reg;
      // Events: logical input/output edges only, gate activity never
      for (k = 0; k < 32; k = k + 1)
      begin
        if ((lin_reg[k] != logic_in_o[k]) && ev_mask_reg[k])
        begin
          event_valid_o <= 1'b1;
          event_code_o <= {`EV_LIN, 8'd0, lin_reg[k], k[4:0]};
        end
        if ((logic_out_i[k] != lout_reg[k]) && ev_mask_reg[32+k])
        begin
          event_valid_o <= 1'b1;
          event_code_o <= {`EV_LOUT, 8'd0, logic_out_i[k], k[4:0]};
        end
      end
      if (event_valid_o)
      begin
        ev_last_reg <= event_code_o;
        gen_count_reg <= gen_count_reg + 1'b1;
      end
      // Stage statistics and operation records
      start_d_reg <= stage_start_i;
      trip_d_reg <= stage_trip_i;
      blk_d_reg <= stage_blocked;
      for (k = 0; k < N_STG; k = k + 1)
      begin
        if (stage_start_i[k] && !start_d_reg[k])
          cnt_start_reg[k] <= cnt_start_reg[k] + 1'b1;
        if (stage_trip_i[k] && !trip_d_reg[k])
          cnt_trip_reg[k] <= cnt_trip_reg[k] + 1'b1;
        if (stage_blocked[k] && !blk_d_reg[k])
          cnt_blk_reg[k] <= cnt_blk_reg[k] + 1'b1;
      end
      if (|(stage_trip_i & ~trip_d_reg))
      begin
        rec_mem[rec_wr_reg] <= {5'd0, active_group_o, timestamp_i,
          stage_fault_value_i, stage_prefault_value_i};
        rec_wr_reg <= (rec_wr_reg == `REC_DEPTH - 1) ? 4'd0 : rec_wr_reg + 1'b1;
        if (rec_cnt_reg != `REC_DEPTH)
          rec_cnt_reg <= rec_cnt_reg + 1'b1;
      end
      if (wr_acc && avs_address_i == `A_CMD)
      begin
        if (avs_writedata_i[`CMD_CLR_STAT])
          for (k = 0; k < N_STG; k = k + 1)
          begin
            cnt_start_reg[k] <= 16'h0000;
            cnt_trip_reg[k] <= 16'h0000;
            cnt_blk_reg[k] <= 16'h0000;
          end
        if (avs_writedata_i[`CMD_CLR_REC])
        begin
          rec_wr_reg <= 4'd0;
          rec_cnt_reg <= 4'd0;
        end
      end
      // Parameter group selection
      active_group_o <= grp_pick;
      // Output matrix with latching
      for (k = 0; k < N_DST; k = k + 1)
      begin
        if (dst_level[k] && route_lat_reg[k])
          latch_reg[k] <= 1'b1;
        else if (clr_pulse_reg || (wr_acc && avs_address_i == `A_CMD && avs_writedata_i[`CMD_CLR_LATCH]))
          latch_reg[k] <= 1'b0;
      end
      // Polarity is applied here only; protection or comms resets never touch it
      relay_o <= (dst_level[N_DO-1:0] | latch_reg[N_DO-1:0]) ^ do_pol_reg;
      led_on_o <= dst_level[N_DST-1:N_DO] | latch_reg[N_DST-1:N_DO];
      led_yellow_o <= led_color_reg;
      // Configuration writes
      if (wr_acc)
      begin
        case (avs_address_i)
          `A_DI_POL: di_pol_reg <= avs_writedata_i[N_DI-1:0];
          `A_DO_POL: do_pol_reg <= avs_writedata_i[N_DO-1:0];
          `A_LED_COLOR: led_color_reg <= avs_writedata_i[N_LED-1:0];
          `A_LIN_MODE: lin_mode_reg <= avs_writedata_i;
          `A_EV_MASK: ev_mask_reg[63:0] <= {ev_mask_reg[31:0], avs_writedata_i};
          `A_STG_SEL: stg_sel_reg <= avs_writedata_i[7:0];
          `A_BLK_SRC: blk_src_reg[stg_sel_reg[1:0]] <= avs_writedata_i[4:0];
          `A_GRP_REQ: grp_req_reg <= avs_writedata_i[7:0];
          `A_GRP_USED: grp_used_reg <= avs_writedata_i[7:0];
          `A_ROUTE_SRC: route_src_reg[avs_writedata_i[12:8]] <= avs_writedata_i[4:0];
          `A_ROUTE_LAT: route_lat_reg <= avs_writedata_i[N_DST-1:0];
          `A_DLY_SEL: dly_sel_reg <= avs_writedata_i[7:0];
          `A_DLY_ON: dly_on_reg[dly_sel_reg[2:0]] <= avs_writedata_i[`DELAY_W-1:0];
          `A_DLY_OFF: dly_off_reg[dly_sel_reg[2:0]] <= avs_writedata_i[`DELAY_W-1:0];
          `A_REC_RD: {rec_word_reg, rec_rd_reg} <= avs_writedata_i[5:0];
          default: ;
        endcase
      end
    end
  end
endmodule

// ---- field_side_model.sv ----
// Field contacts and operator panel on the far side of the I/O matrix
module field_side_model #(parameter N_DI = 8) (
  input wire core_clk_i,
  output logic [N_DI-1:0] di_raw_o,
  output logic back_key_o,
  output logic mimic_shown_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    di_raw_o = '0;
    back_key_o = 1'b0;
    mimic_shown_o = 1'b0;
  end
  task automatic set_contacts(input logic [N_DI-1:0] lvl);
    @(posedge core_clk_i);
    di_raw_o <= lvl;
  endtask
  // Key counts only with the mimic up, so the press sits inside that span
  task automatic press_back();
    @(posedge core_clk_i);
    mimic_shown_o <= 1'b1;
    @(posedge core_clk_i);
    back_key_o <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    back_key_o <= 1'b0;
    @(posedge core_clk_i);
    mimic_shown_o <= 1'b0;
  endtask
endmodule

// ---- test_bay_io_matrix.sv ----
// Self-checking bench of the bay I/O matrix
`include "bay_io_defines.vh"
module test_bay_io_matrix;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d;} row_t;
  logic clk, nrst, rd, wr, back_key, mimic, ev_valid, waitreq, ws, pulse_seen;
  logic [7:0] addr, di_raw, relay, di_state;
  logic [31:0] wdata, rdata, rs, q, logic_out, logic_in;
  logic [3:0] st_start, st_trip;
  logic [15:0] led_on, led_yellow, ev_code;
  logic [2:0] grp;
  logic [63:0] net_st, net_ok;
  int error_cnt, tests_run, ev_cnt;
  row_t rows[15] = '{'{`A_DO_POL, 1'b0, 32'h0000_0000}, '{`A_LED_COLOR, 1'b0, 32'h0000_0000},
    '{`A_LIN_MODE, 1'b0, 32'h0000_0000}, '{`A_GRP_USED, 1'b0, 32'h0000_0001},
    '{`A_NET_LO, 1'b0, 32'h9ABC_DEF0}, '{`A_NET_HI, 1'b0, 32'h1234_5678},
    '{`A_QUAL_LO, 1'b0, 32'h0F0F_F0F0}, '{`A_QUAL_HI, 1'b0, 32'h0000_FFFF},
    '{`A_LIN_SET, 1'b1, 32'h0000_0005}, '{`A_LIN_STAT, 1'b0, 32'h0000_0005},
    '{`A_LIN_CLR, 1'b1, 32'h0000_0001}, '{`A_LIN_STAT, 1'b0, 32'h0000_0004},
    '{8'h7C, 1'b1, 32'hFFFF_FFFF}, '{8'h7C, 1'b0, 32'h0000_0000}, '{`A_LIN_CLR, 1'b1, 32'hFFFF_FFFF}};
  bay_io_matrix #(.TICK_DIV(10)) uut (.core_clk_i(clk), .nrst_i(nrst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .di_raw_i(di_raw), .logic_out_i(logic_out), .net_status_i(net_st),
    .net_msg_valid_i(net_ok), .stage_start_i(st_start), .stage_trip_i(st_trip),
    .stage_fault_value_i(32'h0000_0064), .stage_prefault_value_i(32'h0000_0032), .timestamp_i(32'h0000_1000),
    .back_key_i(back_key), .mimic_shown_i(mimic), .relay_o(relay), .led_on_o(led_on), .led_yellow_o(led_yellow),
    .logic_in_o(logic_in), .di_state_o(di_state), .active_group_o(grp), .event_valid_o(ev_valid),
    .event_code_o(ev_code));
  field_side_model fld (.core_clk_i(clk), .di_raw_o(di_raw), .back_key_o(back_key), .mimic_shown_o(mimic));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Mid-cycle samples equal what the next rising edge sees, free of races
  always @(negedge clk)
  begin
    ws = waitreq;
    rs = rdata;
    if (ev_valid === 1'b1)
      ev_cnt++;
    if (logic_in[1] === 1'b1)
      pulse_seen = 1'b1;
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    chk_reg(got, exp);
  endtask
  task automatic bus_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ws !== 1'b0 && n < 20);
    if (n >= 20)
      chk_reg({31'h0000_0000, ws}, 32'h0000_0000);
    q = rs;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    {nrst, rd, wr, pulse_seen} = 4'h0;
    {addr, wdata, logic_out, st_start, st_trip} = '0;
    net_st = 64'h1234_5678_9ABC_DEF0;
    net_ok = 64'hFFFF_0000_F0F0_0F0F;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 15; i++)
    begin
      bus_xfer(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w)
        chk_reg(q, rows[i].d);
    end
    bus_xfer(`A_LIN_MODE, 1'b1, 32'h0000_0002);
    bus_xfer(`A_LIN_SET, 1'b1, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk_pin({logic_in[31:2], pulse_seen, logic_in[0]}, 32'h0000_0002);
    chk_pin(logic_in, 32'h0000_0000);
    bus_xfer(`A_ROUTE_SRC, 1'b1, 32'h0000_0010);
    bus_xfer(`A_ROUTE_SRC, 1'b1, 32'h0000_0112);
    bus_xfer(`A_ROUTE_LAT, 1'b1, 32'h0000_0002);
    bus_xfer(`A_LIN_SET, 1'b1, 32'h0000_0005);
    fld.press_back();
    repeat (3) @(posedge clk);
    chk_pin(32'(relay), 32'h0000_0003);
    bus_xfer(`A_LIN_CLR, 1'b1, 32'h0000_0005);
    repeat (3) @(posedge clk);
    chk_pin(32'(relay), 32'h0000_0002);
    fld.press_back();
    repeat (3) @(posedge clk);
    chk_pin(32'(relay), 32'h0000_0000);
    bus_xfer(`A_DO_POL, 1'b1, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk_pin(32'(relay), 32'h0000_0001);
    chk_reg(ev_cnt, 32'h0000_0000);
    bus_xfer(`A_EV_MASK, 1'b1, 32'h0000_0000);
    bus_xfer(`A_EV_MASK, 1'b1, 32'h0000_0001);
    bus_xfer(`A_LIN_SET, 1'b1, 32'h0000_0001);
    bus_xfer(`A_LIN_CLR, 1'b1, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk_reg(ev_cnt, 32'h0000_0002);
    bus_xfer(`A_EV_MASK, 1'b1, 32'h0000_0001);
    bus_xfer(`A_EV_MASK, 1'b1, 32'h0000_0000);
    logic_out <= 32'h0000_0001;
    repeat (3) @(posedge clk);
    logic_out <= 32'h0000_0000;
    repeat (3) @(posedge clk);
    chk_reg(ev_cnt, 32'h0000_0004);
    bus_xfer(`A_DLY_SEL, 1'b1, 32'h0000_0000);
    bus_xfer(`A_DLY_ON, 1'b1, 32'h0000_0003);
    fld.set_contacts(8'h01);
    repeat (15) @(posedge clk);
    chk_pin(32'(di_state), 32'h0000_0000);
    repeat (35) @(posedge clk);
    chk_pin(32'(di_state), 32'h0000_0001);
    bus_xfer(`A_DI_POL, 1'b1, 32'h0000_0002);
    repeat (15) @(posedge clk);
    chk_pin(32'(di_state), 32'h0000_0003);
    st_start <= 4'h1;
    bus_xfer(`A_STG_STAT, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0001);
    st_trip <= 4'h1;
    bus_xfer(`A_STG_STAT, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0002);
    bus_xfer(`A_STG_CNT, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0001_0001);
    bus_xfer(`A_REC_RD, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0010);
    bus_xfer(`A_REC_DATA, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0032);
    bus_xfer(`A_REC_RD, 1'b1, 32'h0000_0020);
    bus_xfer(`A_REC_DATA, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_1000);
    bus_xfer(`A_ROUTE_SRC, 1'b1, 32'h0000_0208);
    bus_xfer(`A_BLK_SRC, 1'b1, 32'h0000_0000);
    bus_xfer(`A_STG_STAT, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0003);
    chk_pin(32'(relay[2]), 32'h0000_0001);
    bus_xfer(`A_BLK_SRC, 1'b1, 32'h0000_001F);
    bus_xfer(`A_BLK_SRC, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0001_001F);
    chk_pin(32'(relay[2]), 32'h0000_0000);
    bus_xfer(`A_CMD, 1'b1, 32'h0000_0003);
    bus_xfer(`A_STG_CNT, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0000);
    bus_xfer(`A_REC_RD, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0000);
    bus_xfer(`A_EV_CODE, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0004_4000);
    net_ok[63:32] <= 32'h0000_0000;
    net_st[63:32] <= 32'hA5A5_0000;
    bus_xfer(`A_QUAL_HI, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'hFFFF_FFFF);
    bus_xfer(`A_NET_HI, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'hA5A5_0000);
    bus_xfer(`A_GRP_USED, 1'b1, 32'h0000_00FF);
    bus_xfer(`A_GRP_REQ, 1'b1, 32'h0000_0084);
    @(posedge clk);
    chk_pin(32'(grp), 32'h0000_0002);
    bus_xfer(`A_GRP_REQ, 1'b1, 32'h0000_0081);
    @(posedge clk);
    chk_pin(32'(grp), 32'h0000_0000);
    bus_xfer(`A_LED_COLOR, 1'b1, 32'h0000_FFFF);
    @(posedge clk);
    chk_pin(32'(led_yellow), 32'h0000_FFFF);
    logic_out <= 32'h0000_0001;
    st_start <= 4'h1;
    st_trip <= 4'h1;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_pin({relay, led_yellow, 5'h00, grp}, 32'h0000_0000);
    nrst <= 1'b1;
    @(posedge clk);
    bus_xfer(`A_GRP_USED, 1'b0, 32'h0000_0000);
    chk_reg(q, 32'h0000_0001);
    give_verdict();
  end
endmodule
